// file: logic/metering_config_regs.sv
// Metering configuration registers reached over the serial link
// Operation
// - Conversion starts settle count plus one clocks later
// - Host software should leave settling register alone
// - Enabled interrupt pulses per received character
// - Select polarity bit chooses active level
// - Character length bit picks 8 or 16
// - Phase bit picks leading or trailing sample
// - Polarity bit sets serial clock idle level
// - Stalled transactions expire after programmed frames
// - Hold-off counter decrements each DSP cycle until it reaches zero
// - Hold-off above one discards the DSP cycle
// - Above threshold one use second compensation set
// - Above threshold two use third compensation set
// - Neutral quantity scaled by gain over 2^14
// - Each phase energy scaled by own gain
`timescale 1ns/1ns
`default_nettype none
`include "metering_defs.svh"
module metering_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link to the host
  spi_link_if.dev link,
  // Analog front-end sequencing
  input wire logic mux_switch,
  output logic conv_start,
  // Frame and DSP cadence
  input wire logic frame_tick,
  input wire logic dsp_tick,
  output logic acc_en,
  output logic discard,
  // Serial port events
  output logic char_irq,
  output logic spi_timeout,
  // Phase-angle compensation
  input wire logic [15:0] current_in,
  output metering_pkg::pa_set_t pa_set,
  // Gain scaling
  input wire logic [15:0] neutral_raw,
  input wire logic [2:0][15:0] ef_raw,
  output logic [17:0] neutral_scaled,
  output logic [2:0][17:0] ef_scaled
);
  import metering_pkg::*;

  dev_state_t s_reg, s_next;
  logic sel, edge_seen, lead, smp, wr_en;
  logic [9:0] wr_addr;
  logic [15:0] wr_data;

  // Register read map; unmapped addresses answer zero
  function automatic logic [15:0] rd(input logic [9:0] a);
    logic [15:0] v;
    v = '0;
    case (a)
      `OFS_SETTLE: v = s_reg.settle;
      `OFS_SPICFG: v = {8'h00, s_reg.cfg & `CFG_MASK};
      `OFS_TIMEOUT: v = s_reg.timeout;
      `OFS_HOLDOFF: v = s_reg.holdoff;
      `OFS_THR1: v = s_reg.thr1;
      `OFS_THR2: v = s_reg.thr2;
      `OFS_NGAIN: v = s_reg.ngain;
      `OFS_EFGAIN_A: v = s_reg.efgain[0];
      `OFS_EFGAIN_B: v = s_reg.efgain[1];
      `OFS_EFGAIN_C: v = s_reg.efgain[2];
      default: v = '0;
    endcase
    return v;
  endfunction

  // Link decode from the synchronised pins; first stages stay private
  always_comb begin
    sel = s_reg.cfg[`CFG_SEL_POL] ? s_reg.ssel_s : ~s_reg.ssel_s;
    edge_seen = s_reg.sclk_s != s_reg.sclk_d;
    lead = s_reg.sclk_d == s_reg.cfg[`CFG_CPOL];
    smp = sel && edge_seen && (lead ^ s_reg.cfg[`CFG_CPHA])
          && !s_reg.aborted && (s_reg.bit_cnt < `FRAME_BITS);
  end

  // Next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    wr_en = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    s_next.conv_start = 1'b0;
    s_next.char_irq = 1'b0;
    s_next.spi_timeout = 1'b0;
    s_next.acc_en = 1'b0;
    s_next.discard = 1'b0;
    // Two flip-flops on every pin from the host
    s_next.sclk_m = link.sclk;
    s_next.sclk_s = s_reg.sclk_m;
    s_next.sclk_d = s_reg.sclk_s;
    s_next.ssel_m = link.ssel;
    s_next.ssel_s = s_reg.ssel_m;
    s_next.mosi_m = link.mosi;
    s_next.mosi_s = s_reg.mosi_m;
    s_next.sel_d = sel;

    // Shift engine; deselect clears any partial frame
    if (!sel) begin
      s_next.bit_cnt = '0;
      s_next.aborted = 1'b0;
      s_next.tx = '0;
      s_next.to_cnt = '0;
    end else if (smp) begin
      s_next.rx = {s_reg.rx[30:0], s_reg.mosi_s};
      s_next.bit_cnt = s_reg.bit_cnt + 6'd1;
      s_next.to_cnt = '0;
      s_next.tx = {s_reg.tx[14:0], 1'b0};
      // Read data is fetched once the command word is complete
      if (s_next.bit_cnt == `CMD_BITS)
        s_next.tx = rd(s_next.rx[9:0]);
      // Character boundary at 8 or 16 bits
      if ((s_reg.cfg[`CFG_CHAR16] ? s_next.bit_cnt[3:0] == 4'h0
                                 : s_next.bit_cnt[2:0] == 3'h0)
          && s_reg.cfg[`CFG_IRQ_EN])
        s_next.char_irq = 1'b1;
      if (s_next.bit_cnt == `FRAME_BITS && s_next.rx[31]) begin
        wr_en = 1'b1;
        wr_addr = s_next.rx[25:16];
        wr_data = s_next.rx[15:0];
      end
    end else if (frame_tick && s_reg.bit_cnt != 6'd0 && !s_reg.aborted
                 && s_reg.bit_cnt < `FRAME_BITS && s_reg.timeout != '0) begin
      // Count idle frames mid-transfer; expire at the programmed count
      s_next.to_cnt = s_reg.to_cnt + 16'h0001;
      if (s_next.to_cnt >= s_reg.timeout) begin
        s_next.aborted = 1'b1;
        s_next.spi_timeout = 1'b1;
        s_next.bit_cnt = '0;
        s_next.tx = '0;
      end
    end

    // Hold-off counter gates energy accumulation per DSP cycle
    if (dsp_tick) begin
      if (s_reg.holdoff != '0) begin
        s_next.holdoff = s_reg.holdoff - 16'h0001;
        if (s_next.holdoff != '0)
          s_next.discard = 1'b1;
        else
          s_next.acc_en = 1'b1;
      end else begin
        s_next.acc_en = 1'b1;
      end
    end

    // Register writes; a write beats a same-cycle hold-off decrement
    if (wr_en) begin
      case (wr_addr)
        `OFS_SETTLE: s_next.settle = wr_data;
        `OFS_SPICFG: s_next.cfg = wr_data[7:0] & `CFG_MASK;
        `OFS_TIMEOUT: s_next.timeout = wr_data;
        `OFS_HOLDOFF: s_next.holdoff = wr_data;
        `OFS_THR1: s_next.thr1 = wr_data;
        `OFS_THR2: s_next.thr2 = wr_data;
        `OFS_NGAIN: s_next.ngain = wr_data;
        `OFS_EFGAIN_A: s_next.efgain[0] = wr_data;
        `OFS_EFGAIN_B: s_next.efgain[1] = wr_data;
        `OFS_EFGAIN_C: s_next.efgain[2] = wr_data;
        default: ;
      endcase
    end

    // Settling delay: count down from the register, pulse at zero
    if (mux_switch) begin
      s_next.settle_cnt = s_reg.settle;
      s_next.settle_busy = 1'b1;
    end else if (s_reg.settle_busy) begin
      if (s_reg.settle_cnt == '0) begin
        s_next.conv_start = 1'b1;
        s_next.settle_busy = 1'b0;
      end else begin
        s_next.settle_cnt = s_reg.settle_cnt - 16'h0001;
      end
    end

    // Compensation set chosen by current against both thresholds
    if (current_in > s_reg.thr2)
      s_next.pa_set = PA_THIRD;
    else if (current_in > s_reg.thr1)
      s_next.pa_set = PA_SECOND;
    else
      s_next.pa_set = PA_FIRST;

    // Gain scaling keeps the full integer part, no saturation
    s_next.n_scaled = 18'((32'(neutral_raw) * 32'(s_reg.ngain))
                          >> `GAIN_SHIFT);
    for (int i = 0; i < 3; i++)
      s_next.ef_scaled[i] = 18'((32'(ef_raw[i]) * 32'(s_reg.efgain[i]))
                                >> `GAIN_SHIFT);
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= '0;
      // Select synchroniser starts at the idle level of the default
      // active-low select, so no phantom frame follows reset
      s_reg.ssel_m <= 1'b1;
      s_reg.ssel_s <= 1'b1;
      s_reg.settle <= `RST_SETTLE;
      s_reg.cfg <= `RST_SPICFG;
      s_reg.timeout <= `RST_TIMEOUT;
      s_reg.holdoff <= `RST_HOLDOFF;
      s_reg.thr1 <= `RST_THR;
      s_reg.thr2 <= `RST_THR;
      s_reg.ngain <= `RST_GAIN;
      s_reg.efgain <= {3{`RST_GAIN}};
      s_reg.pa_set <= PA_FIRST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign link.miso = s_reg.tx[15];
  assign link.miso_oe = s_reg.sel_d;
  assign conv_start = s_reg.conv_start;
  assign acc_en = s_reg.acc_en;
  assign discard = s_reg.discard;
  assign char_irq = s_reg.char_irq;
  assign spi_timeout = s_reg.spi_timeout;
  assign pa_set = s_reg.pa_set;
  assign neutral_scaled = s_reg.n_scaled;
  assign ef_scaled = s_reg.ef_scaled;
endmodule // metering_config_regs
`default_nettype wire

// file: inc/metering_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef METERING_DEFS_SVH
`define METERING_DEFS_SVH
// Register offsets (10-bit register address carried in the command word)
`define OFS_SETTLE 10'h050
`define OFS_SPICFG 10'h052
`define OFS_TIMEOUT 10'h054
`define OFS_HOLDOFF 10'h058
`define OFS_THR1 10'h05C
`define OFS_THR2 10'h05E
`define OFS_NGAIN 10'h12E
`define OFS_EFGAIN_A 10'h136
`define OFS_EFGAIN_B 10'h222
`define OFS_EFGAIN_C 10'h30E
// Serial port configuration field positions
`define CFG_IRQ_EN 7
`define CFG_SEL_POL 6
`define CFG_CHAR16 2
`define CFG_CPHA 1
`define CFG_CPOL 0
`define CFG_MASK 8'hC7
// Reset values
`define RST_SETTLE 16'h002F
`define RST_SPICFG 8'h80
`define RST_TIMEOUT 16'h0001
`define RST_HOLDOFF 16'h0005
`define RST_THR 16'h0000
`define RST_GAIN 16'h4000
`define GAIN_SHIFT 14
// Frame layout: 16-bit command (write flag, address) then 16 data bits
`define FRAME_BITS 6'd32
`define CMD_BITS 6'd16
// Serial clock made by the host end: half period in ns and in clocks
`define CLK_PERIOD_NS 100
`define SCLK_HALF_NS 400
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: inc/metering_pkg.sv
// Types shared by both ends of the metering configuration link
package metering_pkg;
  typedef enum logic [1:0] {PA_FIRST, PA_SECOND, PA_THIRD} pa_set_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_RUN, H_GAP, H_HOLD,
                            H_REST} host_fsm_t;
  typedef struct packed {
    logic sclk_m, sclk_s, sclk_d, ssel_m, ssel_s, mosi_m, mosi_s, sel_d;
    logic [5:0] bit_cnt;
    logic [31:0] rx;
    logic [15:0] tx;
    logic aborted;
    logic [15:0] to_cnt;
    logic [15:0] settle, timeout, holdoff, thr1, thr2, ngain;
    logic [7:0] cfg;
    logic [2:0][15:0] efgain;
    logic [15:0] settle_cnt;
    logic settle_busy, conv_start, char_irq, spi_timeout, acc_en, discard;
    pa_set_t pa_set;
    logic [17:0] n_scaled;
    logic [2:0][17:0] ef_scaled;
  } dev_state_t;
  typedef struct packed {
    host_fsm_t fsm;
    logic [3:0] div_cnt;
    logic sclk, ssel_act, first, miso_m, miso_s, resp_valid;
    logic [5:0] bit_cnt;
    logic [31:0] tx;
    logic [15:0] rx, rdata;
  } host_state_t;
endpackage

// file: inc/spi_link_if.sv
// Serial link between the metering device end and the host end
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic ssel;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev(input sclk, input ssel, input mosi, output miso,
              output miso_oe);
  modport host(output sclk, output ssel, output mosi, input miso,
               input miso_oe);
endinterface
`default_nettype wire

// file: logic/metering_host_master.sv
// Host end: serial master that reads and writes the metering registers
`timescale 1ns/1ns
`default_nettype none
`include "metering_defs.svh"
module metering_host_master (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link to the device
  spi_link_if.host link,
  // Link format, must match the device configuration
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sel_pol,
  input wire logic char16,
  // Request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [9:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  // Answer side
  output logic resp_valid,
  output logic [15:0] resp_rdata
);
  import metering_pkg::*;

  host_state_t s_reg, s_next;
  logic tick, lead, smp;

  // Half-period divider and edge kind of the next toggle
  always_comb begin
    tick = s_reg.div_cnt == 4'(`SCLK_HALF_CYC - 1);
    lead = s_reg.sclk == cpol;
    smp = lead ^ cpha;
  end

  // Master sequencer
  always_comb begin
    s_next = s_reg;
    s_next.resp_valid = 1'b0;
    s_next.miso_m = link.miso;
    s_next.miso_s = s_reg.miso_m;
    s_next.div_cnt = tick ? 4'h0 : s_reg.div_cnt + 4'h1;
    unique case (s_reg.fsm)
      H_IDLE: begin
        s_next.div_cnt = 4'h0;
        s_next.sclk = cpol;
        if (req_valid) begin
          s_next.tx = {req_write, 5'h00, req_addr, req_wdata};
          s_next.ssel_act = 1'b1;
          s_next.bit_cnt = '0;
          s_next.first = 1'b1;
          s_next.fsm = H_SETUP;
        end
      end
      H_SETUP: if (tick) s_next.fsm = H_RUN;
      H_RUN: if (tick) begin
        s_next.sclk = ~s_reg.sclk;
        s_next.first = 1'b0;
        // Sample on one edge, launch on the other (never the first)
        if (smp)
          s_next.rx = {s_reg.rx[14:0], s_reg.miso_s};
        else if (!s_reg.first)
          s_next.tx = {s_reg.tx[30:0], 1'b0};
        if (!lead) begin
          s_next.bit_cnt = s_reg.bit_cnt + 6'd1;
          if (s_next.bit_cnt == `FRAME_BITS)
            s_next.fsm = H_HOLD;
          else if (char16 ? s_next.bit_cnt[3:0] == 4'h0
                          : s_next.bit_cnt[2:0] == 3'h0)
            s_next.fsm = H_GAP;
        end
      end
      H_GAP: if (tick) s_next.fsm = H_RUN;
      H_HOLD: if (tick) begin
        s_next.ssel_act = 1'b0;
        s_next.resp_valid = 1'b1;
        s_next.rdata = s_reg.rx;
        s_next.fsm = H_REST;
      end
      H_REST: if (tick) s_next.fsm = H_IDLE;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.fsm <= H_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pins and answers; select level follows the chosen polarity
  assign link.sclk = s_reg.sclk;
  assign link.ssel = sel_pol ? s_reg.ssel_act : ~s_reg.ssel_act;
  assign link.mosi = s_reg.tx[31];
  assign req_ready = s_reg.fsm == H_IDLE;
  assign resp_valid = s_reg.resp_valid;
  assign resp_rdata = s_reg.rdata;
endmodule // metering_host_master
`default_nettype wire

// file: tb/metering_config_regs_properties.sv
// Wire-level checks on the serial link between host end and device end
`timescale 1ns/1ns
`default_nettype none
module metering_config_regs_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link wires
  input wire logic sclk,
  input wire logic ssel,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  // Link format held by the host end
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sel_pol
);
  logic act;
  logic sclk_d_reg;
  logic [6:0] edges_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Host view of the select line
  assign act = (ssel == sel_pol);
  // Edges per frame; the count is dropped while deselected
  always_ff @(posedge clk) begin
    sclk_d_reg <= sclk;
    if (!resetn || !act) edges_reg <= 7'h00;
    else if (sclk != sclk_d_reg) edges_reg <= edges_reg + 7'h01;
  end
  // Sampling edge: leading when phase clear, trailing when set
  sequence s_sample;
    act && $changed(sclk) && (sclk ^ cpol ^ cpha);
  endsequence
  a_frame_edge_count: assert property (
    $changed(ssel) && !act && $past(sel_pol, 2) == sel_pol
    |-> edges_reg == 7'h40) else $error("frame edge count wrong");
  a_sclk_half_period: assert property (
    $changed(sclk) && act |=> $stable(sclk)[*3])
    else $error("serial clock half period short");
  a_mosi_at_sample: assert property (
    s_sample |-> $stable(mosi) ##1 $stable(mosi))
    else $error("mosi moved at sample edge");
  a_miso_at_sample: assert property (
    s_sample |-> $stable(miso)) else $error("miso moved at sample edge");
  a_sclk_idle_level: assert property (
    (!act && $stable(cpol))[*6] |=> sclk == cpol)
    else $error("serial clock idle level wrong");
  a_sclk_frame_start: assert property (
    $changed(ssel) && act |-> sclk == cpol)
    else $error("frame began off idle level");
  a_oe_when_idle: assert property (
    (!act)[*8] |-> !miso_oe) else $error("miso driven while deselected");
  a_select_gap: assert property (
    $changed(ssel) && !act |=> (!act)[*3])
    else $error("deselect gap too short");
endmodule // metering_config_regs_properties
`default_nettype wire

// file: tb/metering_config_regs_bench.sv
// Self-checking bench joining the host end to the device end
`timescale 1ns/1ns
`default_nettype none
`include "metering_defs.svh"
module metering_config_regs_bench;
  import metering_pkg::*;
  logic clk, resetn, mux_switch, conv_start, frame_tick, dsp_tick, acc_en;
  logic discard, char_irq, spi_timeout, cpol, cpha, sel_pol, char16;
  logic req_valid, req_write, req_ready, resp_valid;
  logic [9:0] req_addr;
  logic [15:0] req_wdata, resp_rdata, current_in, neutral_raw;
  logic [2:0][15:0] ef_raw;
  logic [17:0] neutral_scaled;
  logic [2:0][17:0] ef_scaled;
  pa_set_t pa_set;
  int num_errors, samples_checked, cycles, irqs, accs, drops, tmos;
  spi_link_if link();
  metering_config_regs metering_config_regs_inst (.clk, .resetn, .link,
    .mux_switch, .conv_start, .frame_tick, .dsp_tick, .acc_en, .discard,
    .char_irq, .spi_timeout, .current_in, .pa_set, .neutral_raw, .ef_raw,
    .neutral_scaled, .ef_scaled);
  metering_host_master metering_host_master_inst (.clk, .resetn, .link,
    .cpol, .cpha, .sel_pol, .char16, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .resp_valid, .resp_rdata);
  metering_config_regs_properties props_inst (.clk, .resetn,
    .sclk(link.sclk), .ssel(link.ssel), .mosi(link.mosi), .miso(link.miso),
    .miso_oe(link.miso_oe), .cpol, .cpha, .sel_pol);
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Event tallies; the run needs about 26000 cycles, so 40000 is a hang
  always @(posedge clk) begin
    cycles++;
    if (char_irq === 1'b1) irqs++;
    if (acc_en === 1'b1) accs++;
    if (discard === 1'b1) drops++;
    if (spi_timeout === 1'b1) tmos++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test;
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // One link transfer; the request stays up until the host takes it
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [15:0] d);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
    while (resp_valid !== 1'b1) @(posedge clk) #1;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    chk({2'b00, resp_rdata}, {2'b00, exp});
  endtask
  task automatic t_reset;
    rd(`OFS_SETTLE, 16'h002F);
    rd(`OFS_SPICFG, 16'h0080);
    rd(`OFS_HOLDOFF, 16'h0005);
    rd(`OFS_NGAIN, 16'h4000);
    rd(`OFS_EFGAIN_C, 16'h4000);
    xfer(1'b1, `OFS_SPICFG, 16'h00B8);
    rd(`OFS_SPICFG, 16'h0080);
    rd(10'h100, 16'h0000);
    $display("reset values test done");
  endtask
  task automatic mux_wait(input int exp);
    int n;
    n = 0;
    mux_switch = 1'b1;
    @(posedge clk) #1;
    mux_switch = 1'b0;
    while (conv_start !== 1'b1 && n < 300) begin
      @(posedge clk) #1;
      n++;
    end
    chk(18'(n), 18'(exp));
  endtask
  task automatic t_settle;
    mux_wait(48);
    xfer(1'b1, `OFS_SETTLE, 16'h0003);
    mux_wait(4);
    // Supervisory code leaves the mirror alone; put the default back
    xfer(1'b1, `OFS_SETTLE, 16'h002F);
    mux_wait(48);
    $display("settle test done");
  endtask
  task automatic tick;
    dsp_tick = 1'b1;
    @(posedge clk) #1;
    dsp_tick = 1'b0;
    repeat (3) @(posedge clk) #1;
  endtask
  // Five from reset: four dropped cycles, then accumulation resumes
  task automatic t_holdoff;
    accs = 0;
    drops = 0;
    repeat (6) tick;
    chk(18'(drops), 18'h00004);
    chk(18'(accs), 18'h00002);
    rd(`OFS_HOLDOFF, 16'h0000);
    xfer(1'b1, `OFS_HOLDOFF, 16'h0001);
    tick;
    chk(18'(accs + 10 * drops), 18'h0002B);
    $display("holdoff test done");
  endtask
  task automatic t_pa;
    logic [15:0] cur [4] = '{16'h4000, 16'h4001, 16'h8000, 16'h8001};
    pa_set_t exp [4] = '{PA_FIRST, PA_SECOND, PA_SECOND, PA_THIRD};
    xfer(1'b1, `OFS_THR1, 16'h4000);
    xfer(1'b1, `OFS_THR2, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      current_in = cur[i];
      repeat (2) @(posedge clk) #1;
      chk({16'h0000, pa_set}, {16'h0000, exp[i]});
    end
    $display("phase set test done");
  endtask
  task automatic t_gain;
    chk(neutral_scaled, 18'h0FFFF);
    xfer(1'b1, `OFS_NGAIN, 16'h8000);
    xfer(1'b1, `OFS_EFGAIN_A, 16'h2000);
    xfer(1'b1, `OFS_EFGAIN_C, 16'hC000);
    repeat (2) @(posedge clk) #1;
    chk(neutral_scaled, 18'h1FFFE);
    chk(ef_scaled[0], 18'h07FFF);
    chk(ef_scaled[1], 18'h0FFFF);
    chk(ef_scaled[2], 18'h2FFFD);
    xfer(1'b1, `OFS_EFGAIN_B, 16'h6000);
    repeat (2) @(posedge clk) #1;
    chk(ef_scaled[1], 18'h17FFE);
    rd(`OFS_EFGAIN_A, 16'h2000);
    rd(`OFS_EFGAIN_B, 16'h6000);
    $display("gain test done");
  endtask
  // Frame ticks land mid-frame; two cycles so a sample cycle cannot hide
  // them. A limit of one expires the write, a limit of three lets it land.
  task automatic t_timeout;
    rd(`OFS_TIMEOUT, 16'h0001);
    tmos = 0;
    for (int k = 0; k < 2; k++) begin
      fork
        xfer(1'b1, `OFS_THR2, 16'h1234);
        begin
          repeat (40) @(posedge clk) #1;
          frame_tick = 1'b1;
          repeat (2) @(posedge clk) #1;
          frame_tick = 1'b0;
        end
      join
      if (k == 0) begin
        chk(18'(tmos), 18'h00001);
        rd(`OFS_THR2, 16'h8000);
        xfer(1'b1, `OFS_TIMEOUT, 16'h0003);
      end
    end
    chk(18'(tmos), 18'h00001);
    rd(`OFS_THR2, 16'h1234);
    $display("timeout test done");
  endtask
  // Every format, with reserved bits set and the interrupt mixed in
  task automatic t_format;
    logic [7:0] c;
    for (int f = 0; f < 16; f++) begin
      c = {f[0] ^ f[3], f[3], 3'b111, f[2], f[1], f[0]};
      xfer(1'b1, `OFS_SPICFG, {8'h00, c});
      {sel_pol, char16, cpha, cpol} = 4'(f);
      repeat (8) @(posedge clk) #1;
      xfer(1'b1, `OFS_THR1, {4'(f), 12'hA5C});
      repeat (8) @(posedge clk) #1;
      irqs = 0;
      rd(`OFS_THR1, {4'(f), 12'hA5C});
      repeat (8) @(posedge clk) #1;
      chk(18'(irqs), c[7] ? (c[2] ? 18'h2 : 18'h4) : 18'h0);
      rd(`OFS_SPICFG, {8'h00, c & 8'hC7});
    end
    $display("format test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {resetn, mux_switch, frame_tick, dsp_tick, cpol, cpha} = 6'h00;
    {sel_pol, char16, req_valid, req_write} = 4'h0;
    req_addr = 10'h000;
    req_wdata = 16'h0000;
    current_in = 16'h0000;
    neutral_raw = 16'hFFFF;
    ef_raw = {3{16'hFFFF}};
    repeat (8) @(posedge clk) #1;
    resetn = 1'b1;
    @(posedge clk) #1;
    t_reset;
    t_settle;
    t_holdoff;
    t_pa;
    t_gain;
    t_timeout;
    t_format;
    end_of_test;
  end
endmodule // metering_config_regs_bench
`default_nettype wire
